// [hw/kcir_pkg.sv]
// Constants, field positions and carrier types for the keypad configuration
// and interrupt register bank.
// Assumes a single 100 MHz clock shared by every user of this package.

package kcir_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] REG_WRAP      = 8'h00;  // Pointer value after wrap
    localparam logic [7:0] REG_CFG       = 8'h01;  // keypad_configuration
    localparam logic [7:0] REG_FLAGS     = 8'h02;  // interrupt_flags
    localparam logic [7:0] REG_LOCK      = 8'h03;  // lock_and_event_count
    localparam logic [7:0] REG_FIFO_HEAD = 8'h04;  // Oldest stored event
    localparam logic [7:0] REG_LAST      = 8'h2e;  // pullup_disable_bank3
    localparam logic [7:0] REG_RSVD_HI   = 8'h2f;  // Reserved, never acknowledged

    // ==========================================================
    // Configuration field positions
    localparam int unsigned CFG_AUTO_INCREMENT  = 7;  // auto_increment
    localparam int unsigned CFG_INPUT_LOCK_TRK  = 6;  // input_event_lock_tracking
    localparam int unsigned CFG_OVERRUN_SHIFT   = 5;  // fifo_overrun_shift_mode
    localparam int unsigned CFG_RELEASE_ON_CLR  = 4;  // Release line on blocked clear
    localparam int unsigned CFG_OVERRUN_IEN     = 3;  // fifo_overrun_irq_enable
    localparam int unsigned CFG_LOCK_SEQ_IEN    = 2;  // lock_seq_irq_enable
    localparam int unsigned CFG_INPUT_CHG_IEN   = 1;  // input_change_irq_enable
    localparam int unsigned CFG_KEY_EVENT_IEN   = 0;  // key_event_irq_enable

    // ==========================================================
    // Flag field positions (bits 3 to 0 at the same positions as their enables)
    localparam int unsigned FLG_THREE_KEY_COMBO = 4;  // three_key_combo_flag
    localparam int unsigned FLG_FIFO_OVERRUN    = 3;  // fifo_overrun_flag
    localparam int unsigned FLG_LOCK_SEQ        = 2;  // lock_seq_flag
    localparam int unsigned FLG_INPUT_CHANGE    = 1;  // input_change_flag
    localparam int unsigned FLG_KEY_EVENT       = 0;  // key event flag

    // ==========================================================
    // Lock register field positions
    localparam int unsigned LCK_ENGAGE    = 6;  // lock_engage
    localparam int unsigned LCK_STAGE_TWO = 5;  // lock_stage_two
    localparam int unsigned LCK_STAGE_ONE = 4;  // lock_stage_one

    // ==========================================================
    // Reset values
    localparam logic [7:0] CFG_RST    = 8'h00;
    localparam logic [4:0] FLAGS_RST  = 5'h00;
    localparam logic [3:0] COUNT_RST  = 4'h0;

    // ==========================================================
    // Sizes and timing
    localparam int unsigned FIFO_DEPTH     = 10;   // Stored events
    localparam int unsigned CLOCK_MHZ      = 100;  // Clock rate
    localparam int unsigned RELEASE_US     = 50;   // Line release after blocked clear
    localparam int unsigned RELEASE_CYCLES = RELEASE_US * CLOCK_MHZ;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic       valid;  // One-cycle event strobe
        logic [7:0] code;   // Event code stored in the FIFO
    } kcir_event_s;

    typedef enum logic [1:0] {
        PH_COMMAND,  // Next written byte is the command byte
        PH_DATA,     // Command accepted, bytes move data
        PH_REJECT    // Command refused, bytes ignored until next transfer
    } kcir_phase_e;

endpackage : kcir_pkg

// [hw/kcir_regs.sv]
// Configuration, interrupt flag and lock/event count register bank of a
// keypad scan controller, with the key event FIFO it reports on.
// Assumes a byte-level front end that has already framed the serial bus:
// start strobe, written bytes, read requests, acknowledge answer.

// ==========================================================
// Function
// - Bit 7 picks fixed or advancing pointer
// - Advancing pointer wraps after last register
// - Command naming reserved registers is refused
// - Bit 6 drops input events while locked
// - Bit 5 drops new or pushes oldest
// - Bit 4 releases line briefly on blocked clear
// - Bit 3 gates overrun onto interrupt line
// - Bit 2 gates lock flag onto line
// - Bit 1 gates input change onto line
// - Bit 0 gates key events onto line
// - Line low when enabled flag is set
// - Combo flag drives its own pin only
// - Five flags, each cleared by writing one
// - Key and input flag clears refused while their cause persists
// - Lock flag set when lock sequence starts
// - Bit 6 written locks or unlocks keypad
// - Both stage bits follow lock state
// - Count of stored events, zero to ten
// - Head read pops event and decrements count
// - Input flag clears only when pins clear
module kcir_regs #(
    parameter int unsigned FIFO_DEPTH     = kcir_pkg::FIFO_DEPTH,
    parameter int unsigned RELEASE_CYCLES = kcir_pkg::RELEASE_CYCLES
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // Byte port from the serial front end
    input  wire logic                  xfer_start,
    input  wire logic                  wr_valid,
    input  wire logic [7:0]            wr_byte,
    input  wire logic                  rd_req,
    output logic                       ack_valid,
    output logic                       ack_ok,
    output logic                       rd_valid,
    output logic [7:0]                 rd_data,
    // Events from the scan and lock logic
    input  wire kcir_pkg::kcir_event_s key_ev,
    input  wire kcir_pkg::kcir_event_s gpi_ev,
    input  wire logic                  combo_hit,
    input  wire logic                  lock_seq_start,
    input  wire logic                  unlock_done,
    input  wire logic                  gpi_pending,
    // Outputs to pins and lock logic
    output logic                       irq_n,
    output logic                       combo_irq_n,
    output logic                       keypad_locked
);

    localparam int HW = $clog2(RELEASE_CYCLES + 1);

    // Refuse sizes the 4-bit count, the countdown or its 8-cycle check cannot serve
    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15 || RELEASE_CYCLES < 8) begin : g_bad_param
        $error("kcir_regs: unsupported FIFO_DEPTH or RELEASE_CYCLES");
    end

    // ==========================================================
    // State
    kcir_pkg::kcir_phase_e phase_reg;               // Transfer phase
    logic [7:0]            ptr_reg;                 // Register pointer
    logic [7:0]            cfg_reg;                 // keypad_configuration
    logic [4:0]            flags_reg;               // interrupt_flags
    logic                  engage_reg;              // lock_engage
    logic [3:0]            count_reg;               // event_count
    logic [3:0]            count_next;              // Count after this cycle
    logic [7:0]            fifo_reg  [FIFO_DEPTH];  // Stored events, head at 0
    logic [7:0]            fifo_next [FIFO_DEPTH];  // FIFO after this cycle
    logic [HW-1:0]         hold_reg;                // Line release countdown

    // ==========================================================
    // Decode
    logic       cmd_wr;         // Command byte this cycle
    logic       data_wr;        // Data byte write this cycle
    logic       data_rd;        // Data byte read this cycle
    logic       cmd_ok;         // Command names a served register
    logic [7:0] ptr_adv;        // Pointer after a data byte
    logic       pop;            // Head read removes an event
    logic       push_valid;     // Event enters the FIFO
    logic [7:0] push_code;      // Code of that event
    logic       gpi_take;       // Input event tracked
    logic       overrun;        // Event met a full FIFO
    logic [4:0] flag_set;       // Hardware set requests
    logic [4:0] flag_clr;       // Host clear requests that are allowed
    logic [4:0] flag_busy;      // Causes still present
    logic       start_hold;     // Blocked clear with release mode on
    logic [HW-1:0] hold_next;   // Countdown after this cycle
    logic [7:0] rd_mux;         // Register read value

    assign cmd_wr  = wr_valid && !xfer_start && phase_reg == kcir_pkg::PH_COMMAND;
    assign data_wr = wr_valid && !xfer_start && phase_reg == kcir_pkg::PH_DATA;
    assign data_rd = rd_req && !xfer_start && phase_reg == kcir_pkg::PH_DATA;
    assign cmd_ok  = wr_byte != kcir_pkg::REG_WRAP && wr_byte < kcir_pkg::REG_RSVD_HI;

    // Fixed pointer, or advance with wrap after the last register
    always_comb begin
        if (!cfg_reg[kcir_pkg::CFG_AUTO_INCREMENT]) begin
            ptr_adv = ptr_reg;
        end else if (ptr_reg == kcir_pkg::REG_LAST) begin
            ptr_adv = kcir_pkg::REG_WRAP;
        end else begin
            ptr_adv = ptr_reg + 8'h01;
        end
    end

    // ==========================================================
    // Transfer phase and pointer
    always_ff @(posedge clock) begin
        if (rst) begin
            phase_reg <= kcir_pkg::PH_COMMAND;
            ptr_reg   <= kcir_pkg::REG_WRAP;
        end else if (xfer_start) begin
            phase_reg <= kcir_pkg::PH_COMMAND;  // New transfer expects a command
        end else if (cmd_wr) begin
            phase_reg <= cmd_ok ? kcir_pkg::PH_DATA : kcir_pkg::PH_REJECT;
            if (cmd_ok) begin
                ptr_reg <= wr_byte;
            end
        end else if (data_wr || data_rd) begin
            ptr_reg <= ptr_adv;
        end
    end

    // Acknowledge answer, one cycle after each written byte
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_valid <= 1'b0;
            ack_ok    <= 1'b0;
        end else begin
            ack_valid <= wr_valid && !xfer_start;
            case (phase_reg)
                kcir_pkg::PH_COMMAND: ack_ok <= wr_valid && !xfer_start && cmd_ok;
                kcir_pkg::PH_DATA:    ack_ok <= wr_valid && !xfer_start;
                default:              ack_ok <= 1'b0;  // Refused transfer
            endcase
        end
    end

    // ==========================================================
    // Configuration and lock registers
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= kcir_pkg::CFG_RST;
        end else if (data_wr && ptr_reg == kcir_pkg::REG_CFG) begin
            cfg_reg <= wr_byte;
        end
    end

    // Host write wins over an unlock in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            engage_reg <= 1'b0;
        end else if (data_wr && ptr_reg == kcir_pkg::REG_LOCK) begin
            engage_reg <= wr_byte[kcir_pkg::LCK_ENGAGE];
        end else if (unlock_done) begin
            engage_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Event FIFO
    assign gpi_take   = gpi_ev.valid &&
                        !(engage_reg && cfg_reg[kcir_pkg::CFG_INPUT_LOCK_TRK]);
    assign push_valid = key_ev.valid || gpi_take;
    assign push_code  = key_ev.valid ? key_ev.code : gpi_ev.code;
    assign pop        = data_rd && ptr_reg == kcir_pkg::REG_FIFO_HEAD && count_reg != 4'h0;

    // Pop shifts toward the head, push lands behind the last event
    always_comb begin
        fifo_next  = fifo_reg;
        count_next = count_reg;
        overrun    = 1'b0;
        if (pop) begin
            for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                fifo_next[i] = fifo_reg[i + 1];
            end
            fifo_next[FIFO_DEPTH - 1] = 8'h00;
            count_next = count_reg - 4'h1;
        end
        if (push_valid) begin
            if (count_next < 4'(FIFO_DEPTH)) begin
                fifo_next[count_next] = push_code;
                count_next = count_next + 4'h1;
            end else begin
                overrun = 1'b1;
                if (cfg_reg[kcir_pkg::CFG_OVERRUN_SHIFT]) begin
                    for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
                        fifo_next[i] = fifo_next[i + 1];
                    end
                    fifo_next[FIFO_DEPTH - 1] = push_code;
                end
            end
        end
    end

    // FIFO storage and count
    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= kcir_pkg::COUNT_RST;
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                fifo_reg[i] <= 8'h00;
            end
        end else begin
            count_reg <= count_next;
            fifo_reg  <= fifo_next;
        end
    end

    // ==========================================================
    // Interrupt flags: set wins over a clear in the same cycle
    assign flag_set  = {combo_hit, overrun, lock_seq_start, gpi_take, key_ev.valid};
    assign flag_busy = {3'b000, gpi_pending, count_reg != 4'h0};
    assign flag_clr  = (data_wr && ptr_reg == kcir_pkg::REG_FLAGS) ?
                       (wr_byte[4:0] & ~flag_busy) : 5'h00;

    always_ff @(posedge clock) begin
        if (rst) begin
            flags_reg <= kcir_pkg::FLAGS_RST;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // Blocked clear of an enabled, still-pending flag starts a release
    assign start_hold = data_wr && ptr_reg == kcir_pkg::REG_FLAGS &&
                        cfg_reg[kcir_pkg::CFG_RELEASE_ON_CLR] &&
                        |(wr_byte[3:0] & flags_reg[3:0] & cfg_reg[3:0] & flag_busy[3:0]);

    always_comb begin
        if (start_hold) begin
            hold_next = HW'(RELEASE_CYCLES);
        end else if (hold_reg != '0) begin
            hold_next = hold_reg - HW'(1);
        end else begin
            hold_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            hold_reg <= '0;
        end else begin
            hold_reg <= hold_next;
        end
    end

    // ==========================================================
    // Pin outputs, each straight from a flip-flop
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_n         <= 1'b1;
            combo_irq_n   <= 1'b1;
            keypad_locked <= 1'b0;
        end else begin
            // Enables share the flag positions, bits 3 to 0
            irq_n         <= !((flags_reg[3] && cfg_reg[3] ||
                                flags_reg[2] && cfg_reg[2] ||
                                flags_reg[1] && cfg_reg[1] ||
                                flags_reg[0] && cfg_reg[0]) &&
                               hold_next == '0);
            combo_irq_n   <= !flags_reg[kcir_pkg::FLG_THREE_KEY_COMBO];
            keypad_locked <= engage_reg;
        end
    end

    // ==========================================================
    // Read path
    always_comb begin
        rd_mux = 8'h00;
        if (ptr_reg == kcir_pkg::REG_CFG) begin
            rd_mux = cfg_reg;
        end else if (ptr_reg == kcir_pkg::REG_FLAGS) begin
            rd_mux = {3'b000, flags_reg};
        end else if (ptr_reg == kcir_pkg::REG_LOCK) begin
            rd_mux = {1'b0, engage_reg, engage_reg, engage_reg, count_reg};
        end else if (ptr_reg >= kcir_pkg::REG_FIFO_HEAD &&
                     ptr_reg < kcir_pkg::REG_FIFO_HEAD + 8'(FIFO_DEPTH)) begin
            rd_mux = fifo_reg[4'(ptr_reg - kcir_pkg::REG_FIFO_HEAD)];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= 8'h00;
        end else begin
            rd_valid <= rd_req && !xfer_start;
            rd_data  <= data_rd ? rd_mux : 8'h00;
        end
    end

    // ==========================================================
    // Assertions
    property p_cmd_reserved;
        @(posedge clock) disable iff (rst)
        cmd_wr && (wr_byte == kcir_pkg::REG_WRAP || wr_byte == kcir_pkg::REG_RSVD_HI)
        |=> ack_valid && !ack_ok ##1 (phase_reg == kcir_pkg::PH_REJECT || xfer_start);
    endproperty
    a_cmd_reserved: assert property (p_cmd_reserved) else $error("reserved command acked");

    property p_wrap;
        @(posedge clock) disable iff (rst)
        data_wr && cfg_reg[kcir_pkg::CFG_AUTO_INCREMENT] && ptr_reg == kcir_pkg::REG_LAST
        |=> ptr_reg == kcir_pkg::REG_WRAP;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_fixed_ptr;
        @(posedge clock) disable iff (rst)
        (data_wr || data_rd) && !cfg_reg[kcir_pkg::CFG_AUTO_INCREMENT] |=> $stable(ptr_reg);
    endproperty
    a_fixed_ptr: assert property (p_fixed_ptr) else $error("pointer moved with increment off");

    property p_pop;
        @(posedge clock) disable iff (rst)
        pop && !push_valid |=> count_reg == $past(count_reg) - 4'h1 && rd_valid;
    endproperty
    a_pop: assert property (p_pop) else $error("head read did not decrement count");

    property p_count_max;
        @(posedge clock) disable iff (rst)
        count_reg <= 4'(FIFO_DEPTH);
    endproperty
    a_count_max: assert property (p_count_max) else $error("event count above depth");

    property p_overrun;
        @(posedge clock) disable iff (rst)
        count_reg == 4'(FIFO_DEPTH) && key_ev.valid && !pop
        |=> flags_reg[kcir_pkg::FLG_FIFO_OVERRUN] && count_reg == 4'(FIFO_DEPTH);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_irq_low;
        @(posedge clock) disable iff (rst)
        |(flags_reg[3:0] & cfg_reg[3:0]) && hold_reg == '0 &&
        !cfg_reg[kcir_pkg::CFG_RELEASE_ON_CLR] |=> !irq_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt line not asserted");

    property p_release;
        @(posedge clock) disable iff (rst)
        start_hold |=> irq_n [*8];
    endproperty
    a_release: assert property (p_release) else $error("line not released");

    property p_key_keep;
        @(posedge clock) disable iff (rst)
        data_wr && ptr_reg == kcir_pkg::REG_FLAGS && wr_byte[0] && count_reg != 4'h0 &&
        flags_reg[kcir_pkg::FLG_KEY_EVENT] |=> flags_reg[kcir_pkg::FLG_KEY_EVENT];
    endproperty
    a_key_keep: assert property (p_key_keep) else $error("key flag cleared with events");

    property p_engage;
        @(posedge clock) disable iff (rst)
        data_wr && ptr_reg == kcir_pkg::REG_LOCK
        |=> ##1 keypad_locked == $past(wr_byte[kcir_pkg::LCK_ENGAGE], 2);
    endproperty
    a_engage: assert property (p_engage) else $error("lock control not applied");

endmodule : kcir_regs

// [verif/kcir_host.sv]
// Host model on the byte port of the keypad register bank.
// Assumes the bank answers one cycle after each written or read byte.
module kcir_host (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Requests to the bank
    output logic            xfer_start,
    output logic            wr_valid,
    output logic [7:0]      wr_byte,
    output logic            rd_req,
    // Answers from the bank
    input  wire logic       ack_valid,
    input  wire logic       ack_ok,
    input  wire logic       rd_valid,
    input  wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Idle levels at time zero
    initial begin
        xfer_start = 1'b0;
        wr_valid   = 1'b0;
        wr_byte    = 8'h00;
        rd_req     = 1'b0;
    end

    // Opens a transfer; waits until reset is gone
    task automatic start();
        while (rst !== 1'b0) @(posedge clock);
        @(posedge clock);
        #1 xfer_start = 1'b1;
        @(posedge clock);
        #1 xfer_start = 1'b0;
    endtask : start

    // Writes one byte, returns {ack_valid, ack_ok}
    task automatic put(input logic [7:0] b, output logic [1:0] ans);
        @(posedge clock);
        #1 wr_valid = 1'b1;
        wr_byte = b;
        @(posedge clock);
        #1 wr_valid = 1'b0;
        // Released byte lines show a changing pattern, not the old value
        wr_byte = ~b;
        ans = {ack_valid, ack_ok};
    endtask : put

    // Reads one byte, returns {rd_valid, rd_data}
    task automatic get(output logic [8:0] d);
        @(posedge clock);
        #1 rd_req = 1'b1;
        @(posedge clock);
        #1 rd_req = 1'b0;
        d = {rd_valid, rd_data};
    endtask : get
endmodule : kcir_host

// [verif/tb.sv]
// Self-checking bench of the keypad register bank.
// Assumes kcir_pkg and kcir_regs are compiled first.
`define CHECK(got, exp) \
    checks_done++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Signals
    logic clock = 1'b0, rst = 1'b1, combo_hit = 1'b0, lock_seq_start = 1'b0;
    logic unlock_done = 1'b0, gpi_pending = 1'b0;
    logic xfer_start, wr_valid, rd_req, ack_valid, ack_ok, rd_valid;
    logic irq_n, combo_irq_n, keypad_locked;
    logic [7:0] wr_byte, rd_data;
    kcir_pkg::kcir_event_s key_ev = '0, gpi_ev = '0;
    int err_count = 0, checks_done = 0, cycles = 0;

    always #5 clock = ~clock;

    kcir_regs #(.RELEASE_CYCLES(20)) dut_u (.clock(clock), .rst(rst),
        .xfer_start(xfer_start), .wr_valid(wr_valid), .wr_byte(wr_byte),
        .rd_req(rd_req), .ack_valid(ack_valid), .ack_ok(ack_ok),
        .rd_valid(rd_valid), .rd_data(rd_data), .key_ev(key_ev),
        .gpi_ev(gpi_ev), .combo_hit(combo_hit), .lock_seq_start(lock_seq_start),
        .unlock_done(unlock_done), .gpi_pending(gpi_pending), .irq_n(irq_n),
        .combo_irq_n(combo_irq_n), .keypad_locked(keypad_locked));

    kcir_host host_u (.clock(clock), .rst(rst), .xfer_start(xfer_start),
        .wr_valid(wr_valid), .wr_byte(wr_byte), .rd_req(rd_req),
        .ack_valid(ack_valid), .ack_ok(ack_ok), .rd_valid(rd_valid),
        .rd_data(rd_data));

    // ==========================================================
    // Tasks
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [1:0] ans;
        host_u.start();
        host_u.put(a, ans);
        `CHECK(ans, 2'b11)
        host_u.put(d, ans);
        `CHECK(ans, 2'b11)
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [1:0] ans;
        logic [8:0] d;
        host_u.start();
        host_u.put(a, ans);
        host_u.get(d);
        `CHECK(d, {1'b1, e})
    endtask : rd

    task automatic ev(input logic gpi, input logic [7:0] c);
        @(posedge clock);
        #1 key_ev = {!gpi, c};
        gpi_ev = {gpi, c};
        @(posedge clock);
        #1 key_ev = '0;
        gpi_ev = '0;
    endtask : ev

    // One-cycle pulse: 0 combo, 1 lock start, 2 unlock done
    task automatic pulse(input int sel);
        @(posedge clock);
        #1 {combo_hit, lock_seq_start, unlock_done} = 3'b100 >> sel;
        @(posedge clock);
        #1 {combo_hit, lock_seq_start, unlock_done} = 3'b000;
    endtask : pulse

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : idle

    // Hang guard
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    // ==========================================================
    // Test sequence
    initial begin
        logic [1:0] ans;
        logic [8:0] d;
        repeat (10) @(posedge clock);
        #1 rst = 1'b0;
        for (int a = 1; a < 4; a++) rd(a[7:0], 8'h00);
        `CHECK({irq_n, combo_irq_n, keypad_locked}, 3'b110)
        // Reserved commands are refused for the whole transfer
        host_u.start();
        host_u.put(8'h00, ans);
        `CHECK(ans, 2'b10)
        host_u.put(8'h01, ans);
        `CHECK(ans, 2'b10)
        host_u.start();
        host_u.put(8'h2f, ans);
        `CHECK(ans, 2'b10)
        // Fixed pointer, advancing pointer, wrap to register zero
        wr(8'h01, 8'h04);
        host_u.start();
        host_u.put(8'h01, ans);
        host_u.get(d);
        host_u.get(d);
        `CHECK(d, 9'h104)
        wr(8'h01, 8'h84);
        host_u.start();
        host_u.put(8'h2e, ans);
        host_u.put(8'h55, ans);
        host_u.get(d);
        `CHECK(d, 9'h100)
        host_u.get(d);
        `CHECK(d, 9'h184)
        // Key events, line gating, refused clear, release on clear
        wr(8'h01, 8'h01);
        ev(1'b0, 8'h81);
        ev(1'b0, 8'h02);
        rd(8'h03, 8'h02);
        `CHECK(irq_n, 1'b0)
        wr(8'h01, 8'h00);
        idle(2);
        `CHECK(irq_n, 1'b1)
        wr(8'h01, 8'h11);
        wr(8'h02, 8'h01);
        idle(2);
        `CHECK(irq_n, 1'b1)
        idle(25);
        `CHECK(irq_n, 1'b0)
        wr(8'h01, 8'h01);
        wr(8'h02, 8'h01);
        idle(2);
        `CHECK(irq_n, 1'b0)
        rd(8'h02, 8'h01);
        rd(8'h04, 8'h81);
        rd(8'h03, 8'h01);
        rd(8'h04, 8'h02);
        wr(8'h02, 8'h01);
        rd(8'h02, 8'h00);
        // Overflow in both policies
        for (int m = 0; m < 2; m++) begin
            wr(8'h01, {2'b00, m[0], 5'h08});
            for (int i = 0; i < 11; i++) ev(1'b0, 8'h10 + i[7:0]);
            rd(8'h03, 8'h0a);
            rd(8'h02, 8'h09);
            `CHECK(irq_n, 1'b0)
            wr(8'h01, {2'b00, m[0], 5'h00});
            idle(2);
            `CHECK(irq_n, 1'b1)
            for (int i = 0; i < 10; i++) rd(8'h04, 8'h10 + m[7:0] + i[7:0]);
            wr(8'h02, 8'h09);
            rd(8'h02, 8'h00);
        end
        // Input change flag waits for the per-pin status
        wr(8'h01, 8'h02);
        gpi_pending = 1'b1;
        ev(1'b1, 8'h61);
        wr(8'h02, 8'h02);
        idle(2);
        `CHECK(irq_n, 1'b0)
        gpi_pending = 1'b0;
        wr(8'h02, 8'h02);
        idle(2);
        `CHECK(irq_n, 1'b1)
        rd(8'h04, 8'h61);
        // Lock sequence flag, combination pin
        wr(8'h01, 8'h04);
        pulse(1);
        idle(2);
        `CHECK(irq_n, 1'b0)
        rd(8'h02, 8'h04);
        wr(8'h01, 8'h0f);
        wr(8'h02, 8'h1f);
        pulse(0);
        idle(2);
        `CHECK({irq_n, combo_irq_n}, 2'b10)
        wr(8'h02, 8'h10);
        idle(2);
        `CHECK(combo_irq_n, 1'b1)
        // Lock control, status mirror, input tracking while locked
        wr(8'h01, 8'h40);
        wr(8'h03, 8'h40);
        idle(2);
        `CHECK(keypad_locked, 1'b1)
        ev(1'b1, 8'h62);
        rd(8'h03, 8'h70);
        wr(8'h01, 8'h00);
        ev(1'b1, 8'h63);
        rd(8'h03, 8'h71);
        pulse(2);
        idle(2);
        `CHECK(keypad_locked, 1'b0)
        rd(8'h03, 8'h01);
        final_report();
    end
endmodule : tb
